/* design/data_set_interface.sv */
// Notes on behaviour
// - receive status low when unframed, in reset, or on receive fifo overwrite
// - async output sends two stop bits when stop select high, else one
// - word length select high means 9 data bits, low means 8, everywhere
// - internal rates divide a 4.096 MHz baud clock down to the 16x clock
// - the internal 16x clock appears on its own output pin
// - rate code 000 uses the baud clock input directly as 16x clock
// - codes 001..111 give 38.4k, 19.2k, 9600, 4800, 2400, 1200, 300 bps
// - sync output driven only while output enable high, else released
// - clock mode low shifts output on falling data clock while enabled
// - clock mode high shifts output on rising data clock while enabled
// - clock mode high sends at most eight bits per enable window
// - reset clears fifos, idles async input high, forces both status low
// - after reset no received sync word is stored until one flag word is received
// - sync input sampled on falling data clock only while input enabled
// - clock mode low captures on falling edge of clock AND input enable
// - clock mode low advances on falling edge of clock AND output enable
// - the flag word is 01111110, sent when idle outside a break and used for framing
// - transmit fill flag low when transmit fifo holds two or more words
// - async input low for eleven bit times or more is a break
// - received words wait in a four word receive fifo
`timescale 1ns/1ns
`default_nettype none

module data_set_interface (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        baud_clock_in,
  output logic             sixteen_x_clock_out,
  input  wire logic        async_serial_in,
  output logic             async_serial_out,
  input  wire logic        sync_bit_clock,
  input  wire logic        sync_output_enable,
  input  wire logic        sync_input_enable,
  input  wire logic        sync_serial_in,
  output logic             sync_serial_out,
  output logic             sync_serial_oe_n,
  output logic             transmit_fill_flag,
  output logic             receive_sync_status
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0]                s1;
    logic [5:0]                s2;
    logic [3:0]                prev;
    logic [15:0]               acc;
    logic                      clk16;
    logic [5:0]                ctrl;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    dsi_pkg::serial_state_type arx_state;
    logic [3:0]                arx_sub;
    logic [3:0]                arx_bit;
    logic [8:0]                arx_sh;
    logic [7:0]                brk_cnt;
    logic                      brk;
    logic [3:0][8:0]           tf_mem;
    logic [1:0]                tf_wr;
    logic [1:0]                tf_rd;
    logic [2:0]                tf_cnt;
    logic [8:0]                stx_sh;
    logic [3:0]                stx_left;
    logic [3:0]                stx_win;
    logic                      stx_bit;
    logic                      stx_oe_n;
    logic [7:0]                srx_win;
    logic [8:0]                srx_word;
    logic [3:0]                srx_cnt;
    logic                      framed;
    logic                      overrun;
    logic [3:0][8:0]           rf_mem;
    logic [1:0]                rf_wr;
    logic [1:0]                rf_rd;
    logic [2:0]                rf_cnt;
    dsi_pkg::serial_state_type atx_state;
    logic [3:0]                atx_sub;
    logic [3:0]                atx_bit;
    logic [8:0]                atx_sh;
    logic                      atx_out;
    logic                      tx_fill;
    logic                      rx_stat;
  } state_type;

  state_type   r;
  state_type   next_r;
  logic        bc_edge;
  logic        tick;
  logic [2:0]  rate;
  logic        len9;
  logic [3:0]  last_bit;
  logic        mode;
  logic        sample_ev;
  logic        shift_ev;
  logic        tf_push;
  logic        tf_pop;
  logic        rf_push;
  logic        rf_pop;
  logic        rf_full;
  logic [8:0]  push_word;
  logic [8:0]  load_word;
  logic [7:0]  win_next;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic        half;
    logic [16:0] sum;
    logic        dc_ie;
    logic        dc_ie_prev;
    logic        dc_oe;
    logic        dc_oe_prev;
    logic        access;
    logic        mapped;
    logic [31:0] rdval;
    half       = 1'b0;
    sum        = 17'h00000;
    dc_ie      = 1'b0;
    dc_ie_prev = 1'b0;
    dc_oe      = 1'b0;
    dc_oe_prev = 1'b0;
    access     = 1'b0;
    mapped     = 1'b0;
    rdval      = 32'h00000000;
    next_r     = r;
    tf_push    = 1'b0;
    tf_pop     = 1'b0;
    rf_push    = 1'b0;
    rf_pop     = 1'b0;
    push_word  = 9'h000;
    load_word  = 9'h000;
    win_next   = r.srx_win;
    // async input resets high via its synchroniser, so reset idles it
    next_r.s1   = {sync_serial_in, async_serial_in, sync_input_enable,
                   sync_output_enable, sync_bit_clock, baud_clock_in};
    next_r.s2   = r.s1;
    next_r.prev = r.s2[3:0];
    rate     = r.ctrl[dsi_pkg::CTRL_RATE_MSB:dsi_pkg::CTRL_RATE_LSB];
    len9     = r.ctrl[dsi_pkg::CTRL_WORD_BIT];
    last_bit = len9 ? dsi_pkg::LAST_BIT_9 : dsi_pkg::LAST_BIT_8;
    mode     = r.ctrl[dsi_pkg::CTRL_MODE_BIT];

    // ----------------------------------------------------------
    // rate generator
    // ----------------------------------------------------------
    bc_edge = r.s2[0] ^ r.prev[0];
    if (rate == 3'h0) begin
      half = bc_edge;
    end else if (r.s2[0] && !r.prev[0]) begin
      // fractional step keeps every standard rate exact
      sum = {1'b0, r.acc} + {1'b0, dsi_pkg::RATE_STEP[rate]};
      if (sum >= dsi_pkg::RATE_MODULUS) begin
        half       = 1'b1;
        next_r.acc = 16'(sum - dsi_pkg::RATE_MODULUS);
      end else begin
        next_r.acc = sum[15:0];
      end
    end
    if (half) begin
      next_r.clk16 = !r.clk16;
    end
    tick = half && !r.clk16;

    // ----------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------
    access = psel && penable && !r.pready;
    mapped = (paddr == dsi_pkg::CTRL_OFFSET) || (paddr == dsi_pkg::STATUS_OFFSET);
    rdval  = 32'h00000000;
    if (paddr == dsi_pkg::CTRL_OFFSET) begin
      rdval = {26'h0000000, r.ctrl};
    end else if (paddr == dsi_pkg::STATUS_OFFSET) begin
      rdval = {23'h000000, r.rf_cnt, r.tf_cnt, r.brk, r.rx_stat, r.tx_fill};
    end
    next_r.pready  = access;
    next_r.pslverr = access && !mapped;
    next_r.prdata  = (access && !pwrite) ? rdval : 32'h00000000;
    if (psel && penable && r.pready && pwrite && paddr == dsi_pkg::CTRL_OFFSET) begin
      next_r.ctrl = pwdata[5:0];
    end

    // ----------------------------------------------------------
    // async input parser and break detect
    // ----------------------------------------------------------
    if (tick) begin
      if (r.s2[4]) begin
        next_r.brk_cnt = 8'h00;
        next_r.brk     = 1'b0;
      end else if (r.brk_cnt != dsi_pkg::BREAK_TICKS) begin
        next_r.brk_cnt = r.brk_cnt + 8'h01;
        next_r.brk     = (r.brk_cnt + 8'h01) == dsi_pkg::BREAK_TICKS;
      end
      next_r.arx_sub = r.arx_sub + 4'h1;
      case (r.arx_state)
        dsi_pkg::SER_IDLE: begin
          next_r.arx_sub = 4'h0;
          if (!r.s2[4]) begin
            next_r.arx_state = dsi_pkg::SER_START;
          end
        end
        dsi_pkg::SER_START: begin
          if (r.arx_sub == dsi_pkg::MID_SAMPLE) begin
            next_r.arx_sub   = 4'h0;
            next_r.arx_bit   = 4'h0;
            // a start bit gone by mid-bit is a glitch, not a word
            next_r.arx_state = r.s2[4] ? dsi_pkg::SER_IDLE : dsi_pkg::SER_DATA;
          end
        end
        dsi_pkg::SER_DATA: begin
          if (r.arx_sub == dsi_pkg::LAST_SAMPLE) begin
            next_r.arx_sh  = {r.s2[4], r.arx_sh[8:1]};
            next_r.arx_bit = r.arx_bit + 4'h1;
            if (r.arx_bit == last_bit) begin
              next_r.arx_state = dsi_pkg::SER_STOP;
            end
          end
        end
        dsi_pkg::SER_STOP: begin
          if (r.arx_sub == dsi_pkg::LAST_SAMPLE) begin
            next_r.arx_state = dsi_pkg::SER_IDLE;
            tf_push          = r.s2[4];
            push_word        = len9 ? r.arx_sh : {1'b0, r.arx_sh[8:1]};
          end
        end
        default: begin
          next_r.arx_state = dsi_pkg::SER_IDLE;
        end
      endcase
    end

    // ----------------------------------------------------------
    // sync transmitter
    // ----------------------------------------------------------
    dc_oe      = r.s2[1] && r.s2[2];
    dc_oe_prev = r.prev[1] && r.prev[2];
    if (!r.s2[2]) begin
      next_r.stx_win = 4'h0;
    end
    if (mode) begin
      shift_ev = dc_oe && !dc_oe_prev && r.stx_win != dsi_pkg::WINDOW_BITS;
    end else begin
      shift_ev = !dc_oe && dc_oe_prev;
    end
    next_r.stx_oe_n = !r.s2[2];
    if (shift_ev) begin
      next_r.stx_win = r.stx_win + 4'h1;
      if (r.stx_left == 4'h0) begin
        if (r.tf_cnt != 3'h0) begin
          tf_pop          = 1'b1;
          load_word       = r.tf_mem[r.tf_rd];
          next_r.stx_left = last_bit;
        end else begin
          // idle line carries flags, or the break code while one lasts
          load_word       = r.brk ? dsi_pkg::BREAK_WORD : {1'b0, dsi_pkg::FLAG_WORD};
          next_r.stx_left = dsi_pkg::LAST_BIT_8;
        end
        next_r.stx_bit = load_word[0];
        next_r.stx_sh  = {1'b0, load_word[8:1]};
      end else begin
        next_r.stx_bit  = r.stx_sh[0];
        next_r.stx_sh   = {1'b0, r.stx_sh[8:1]};
        next_r.stx_left = r.stx_left - 4'h1;
      end
    end

    // ----------------------------------------------------------
    // transmit fifo
    // ----------------------------------------------------------
    if (tf_push && (r.tf_cnt != dsi_pkg::FIFO_DEPTH || tf_pop)) begin
      next_r.tf_mem[r.tf_wr] = push_word;
      next_r.tf_wr           = r.tf_wr + 2'h1;
    end else begin
      tf_push = 1'b0; // full: the word is dropped
    end
    if (tf_pop) begin
      next_r.tf_rd = r.tf_rd + 2'h1;
    end
    next_r.tf_cnt  = r.tf_cnt + {2'h0, tf_push} - {2'h0, tf_pop};
    next_r.tx_fill = next_r.tf_cnt < dsi_pkg::FILL_LIMIT;

    // ----------------------------------------------------------
    // sync receiver; data that mimics a flag realigns framing
    // ----------------------------------------------------------
    dc_ie      = r.s2[1] && r.s2[3];
    dc_ie_prev = r.prev[1] && r.prev[3];
    sample_ev  = dc_ie_prev && !dc_ie;
    if (sample_ev) begin
      win_next       = {r.s2[5], r.srx_win[7:1]};
      next_r.srx_win = win_next;
      next_r.overrun = 1'b0;
      if (win_next == dsi_pkg::FLAG_WORD) begin
        next_r.framed  = 1'b1;
        next_r.srx_cnt = 4'h0;
      end else if (r.framed) begin
        next_r.srx_word = {r.s2[5], r.srx_word[8:1]};
        next_r.srx_cnt  = r.srx_cnt + 4'h1;
        if (r.srx_cnt == last_bit) begin
          next_r.srx_cnt = 4'h0;
          rf_push        = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------
    // async output formatter
    // ----------------------------------------------------------
    if (tick) begin
      next_r.atx_sub = r.atx_sub + 4'h1;
      case (r.atx_state)
        dsi_pkg::SER_IDLE: begin
          next_r.atx_sub = 4'h0;
          if (r.rf_cnt != 3'h0) begin
            rf_pop           = 1'b1;
            next_r.atx_sh    = r.rf_mem[r.rf_rd];
            next_r.atx_out   = 1'b0;
            next_r.atx_state = dsi_pkg::SER_START;
          end
        end
        dsi_pkg::SER_START: begin
          if (r.atx_sub == dsi_pkg::LAST_SAMPLE) begin
            next_r.atx_out   = r.atx_sh[0];
            next_r.atx_sh    = {1'b0, r.atx_sh[8:1]};
            next_r.atx_bit   = 4'h0;
            next_r.atx_state = dsi_pkg::SER_DATA;
          end
        end
        dsi_pkg::SER_DATA: begin
          if (r.atx_sub == dsi_pkg::LAST_SAMPLE) begin
            next_r.atx_bit = r.atx_bit + 4'h1;
            next_r.atx_out = r.atx_sh[0];
            next_r.atx_sh  = {1'b0, r.atx_sh[8:1]};
            if (r.atx_bit == last_bit) begin
              next_r.atx_out   = 1'b1;
              next_r.atx_bit   = 4'h0;
              next_r.atx_state = dsi_pkg::SER_STOP;
            end
          end
        end
        dsi_pkg::SER_STOP: begin
          if (r.atx_sub == dsi_pkg::LAST_SAMPLE) begin
            next_r.atx_bit = r.atx_bit + 4'h1;
            if (r.atx_bit == {3'h0, r.ctrl[dsi_pkg::CTRL_STOP_BIT]}) begin
              next_r.atx_state = dsi_pkg::SER_IDLE;
            end
          end
        end
        default: begin
          next_r.atx_state = dsi_pkg::SER_IDLE;
        end
      endcase
    end

    // ----------------------------------------------------------
    // receive fifo; when full the newest word is overwritten
    // ----------------------------------------------------------
    push_word = len9 ? next_r.srx_word : {1'b0, next_r.srx_word[8:1]};
    rf_full   = r.rf_cnt == dsi_pkg::FIFO_DEPTH && !rf_pop;
    if (rf_pop) begin
      next_r.rf_rd = r.rf_rd + 2'h1;
    end
    if (rf_push && rf_full) begin
      next_r.rf_mem[r.rf_wr - 2'h1] = push_word;
      next_r.overrun                = 1'b1;
    end else if (rf_push) begin
      next_r.rf_mem[r.rf_wr] = push_word;
      next_r.rf_wr           = r.rf_wr + 2'h1;
    end
    next_r.rf_cnt  = r.rf_cnt + {2'h0, rf_push && !rf_full} - {2'h0, rf_pop};
    next_r.rx_stat = next_r.framed && !next_r.overrun;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.s1       <= dsi_pkg::SYNC_RESET;
      r.s2       <= dsi_pkg::SYNC_RESET;
      r.ctrl     <= dsi_pkg::CTRL_RESET;
      r.stx_oe_n <= 1'b1;
      r.atx_out  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign sixteen_x_clock_out = r.clk16;
  assign async_serial_out    = r.atx_out;
  assign sync_serial_out     = r.stx_bit;
  assign sync_serial_oe_n    = r.stx_oe_n;
  assign transmit_fill_flag  = r.tx_fill;
  assign receive_sync_status = r.rx_stat;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fill_flag_low: assert property ((next_r.tf_cnt >= 3'h2) |=> !transmit_fill_flag)
    else $error("fill flag high with two or more words queued");
  a_hunt_blocks_store: assert property (rf_push |-> r.framed)
    else $error("word stored before framing");
  a_output_release: assert property (!r.s2[2] |=> sync_serial_oe_n)
    else $error("sync output driven without enable");
  a_window_limit: assert property (mode |-> r.stx_win <= 4'h8)
    else $error("more than eight bits in one enable window");
  a_stop_level: assert property (r.atx_state == dsi_pkg::SER_STOP |-> async_serial_out)
    else $error("stop bit not high");
  a_flag_frames: assert property ((sample_ev && win_next == 8'h7e) |=> r.framed)
    else $error("flag did not establish framing");
  a_overrun_status: assert property ((rf_push && rf_full) |=> !receive_sync_status)
    else $error("overwrite did not drop receive status");
  a_direct_rate: assert property ((rate == 3'h0 && bc_edge) |=>
                                  sixteen_x_clock_out != $past(sixteen_x_clock_out))
    else $error("external 16x clock not followed");
  a_nine_bit_load: assert property ((shift_ev && tf_pop && len9) |=> r.stx_left == 4'h8)
    else $error("nine bit word loaded with wrong length");
  a_fifo_depth: assert property (r.rf_cnt <= 3'h4 && r.tf_cnt <= 3'h4)
    else $error("fifo count beyond depth");
  a_break_seen: assert property ($rose(r.brk) |-> !r.s2[4] && r.brk_cnt == 8'hb0)
    else $error("break flagged early");

  c_word_sent: cover property (shift_ev && tf_pop);
  c_word_stored: cover property (rf_push && !rf_full);
  c_overwrite: cover property (rf_push && rf_full);
  c_break_sent: cover property (shift_ev && r.brk && r.tf_cnt == 3'h0);

endmodule : data_set_interface

`default_nettype wire

/* dv/sync_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module sync_partner (
  input  wire logic pclk,
  input  wire logic sync_serial_out,
  input  wire logic sync_serial_oe_n,
  output logic      sync_bit_clock,
  output logic      sync_output_enable,
  output logic      sync_input_enable,
  output logic      sync_serial_in
);
  // ----------------------------------
  // mode-low controller, 8-bit windows
  // ----------------------------------
  logic tx_q[$];
  logic rx_q[$];
  logic oe_bad = 1'b0;
  initial begin
    sync_bit_clock = 1'b0;
    sync_output_enable = 1'b0;
    sync_input_enable = 1'b0;
    sync_serial_in = 1'b1;
  end
  task automatic window(input int bits = 8);
    sync_output_enable <= 1'b1;
    sync_input_enable <= 1'b1; // raised long before the first falling clock
    for (int b = 0; b < bits; b++) begin
      repeat (8) @(posedge pclk);
      sync_serial_in <= (tx_q.size() > 0) ? tx_q.pop_front() : 1'b0;
      sync_bit_clock <= 1'b1;
      repeat (8) @(posedge pclk);
      rx_q.push_back(sync_serial_out);
      if (sync_serial_oe_n !== 1'b0) oe_bad = 1'b1;
      sync_bit_clock <= 1'b0; // bit taken on this fall
    end
    repeat (8) @(posedge pclk);
    // drop enables while clock is low, else a stray shift
    sync_output_enable <= 1'b0;
    sync_input_enable <= 1'b0;
    sync_serial_in <= ~sync_serial_in;
    // enables stay low long enough to pass the input synchroniser
    repeat (4) @(posedge pclk);
  endtask : window
endmodule : sync_partner
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        baud_clock_in, sixteen_x_clock_out, async_serial_in, async_serial_out;
  logic        sync_bit_clock, sync_output_enable, sync_input_enable, sync_serial_in;
  logic        sync_serial_out, sync_serial_oe_n, transmit_fill_flag, receive_sync_status;
  logic        x16_last;
  logic [7:0]  word, got;
  int          num_errors, total_checks, cycles, ticks, baud_div, t0, n;
  data_set_interface DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_clock_in(baud_clock_in), .sixteen_x_clock_out(sixteen_x_clock_out),
    .async_serial_in(async_serial_in), .async_serial_out(async_serial_out),
    .sync_bit_clock(sync_bit_clock), .sync_output_enable(sync_output_enable),
    .sync_input_enable(sync_input_enable), .sync_serial_in(sync_serial_in),
    .sync_serial_out(sync_serial_out), .sync_serial_oe_n(sync_serial_oe_n),
    .transmit_fill_flag(transmit_fill_flag), .receive_sync_status(receive_sync_status));
  sync_partner partner (.pclk(pclk), .sync_serial_out(sync_serial_out),
    .sync_serial_oe_n(sync_serial_oe_n), .sync_bit_clock(sync_bit_clock),
    .sync_output_enable(sync_output_enable), .sync_input_enable(sync_input_enable),
    .sync_serial_in(sync_serial_in));
  // ----------------------------------
  // clocks, tick count, timeout
  // ----------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // baud pin at a quarter of pclk keeps each level two samples long
  always @(posedge pclk) begin
    baud_div <= baud_div + 1;
    baud_clock_in <= baud_div[1];
    x16_last <= sixteen_x_clock_out;
    if (sixteen_x_clock_out === 1'b1 && x16_last === 1'b0) ticks <= ticks + 1;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  // ----------------------------------
  // helpers
  // ----------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic int exp_ticks(input int code, input int edges);
    int bps[8] = '{0, 38400, 19200, 9600, 4800, 2400, 1200, 300};
    return edges * 16 * bps[code] / 4096000;
  endfunction : exp_ticks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_near(input string what, input int exp, input int seen);
    total_checks++;
    if (seen > exp + 2 || seen < exp - 2) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check_near
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    rd = prdata;
    err = pslverr;
    if (k >= 64) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic send_async(input logic [7:0] w);
    for (int b = 0; b < 11; b++) begin
      async_serial_in <= (b == 0) ? 1'b0 : (b < 9) ? w[b - 1] : 1'b1;
      repeat (64) @(posedge pclk);
    end
  endtask : send_async
  task automatic push(input logic [7:0] w);
    for (int b = 0; b < 8; b++) partner.tx_q.push_back(w[b]);
  endtask : push
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ----------------------------------
  // main sequence
  // ----------------------------------
  initial begin
    {presetn, psel, penable, pwrite, x16_last, baud_clock_in} = 6'h00;
    {paddr, pwdata} = 44'h0;
    async_serial_in = 1'b1;
    {baud_div, ticks, cycles, num_errors, total_checks} = '0;
    seed = 32'ha21f;
    repeat (4) @(posedge pclk);
    check("rx status", 1'b0, receive_sync_status);
    check("fill flag", 1'b0, transmit_fill_flag);
    check("oe_n", 1'b1, sync_serial_oe_n);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, dsi_pkg::CTRL_OFFSET, 32'h0);
    check("ctrl", {26'h0, dsi_pkg::CTRL_RESET}, rd);
    apb(1'b1, 12'h008, 32'h1);
    check("slverr", 1'b1, err);
    apb(1'b0, dsi_pkg::STATUS_OFFSET, 32'h0);
    check("status", 32'h1, {30'h0, rd[1:0]});
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      apb(1'b1, dsi_pkg::CTRL_OFFSET, seed);
      apb(1'b0, dsi_pkg::CTRL_OFFSET, 32'h0);
      check("ctrl", {26'h0, seed[5:0]}, rd);
    end
    for (int c = 7; c >= 0; c--) begin
      apb(1'b1, dsi_pkg::CTRL_OFFSET, 32'(c) << 2);
      repeat (64) @(posedge pclk);
      t0 = ticks;
      repeat (4096) @(posedge pclk);
      check_near("ticks", (c == 0) ? 1024 : exp_ticks(c, 1024), ticks - t0);
    end
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      send_async(seed[7:0]);
      if (k == 0) check("fill flag", 1'b1, transmit_fill_flag);
    end
    check("fill flag", 1'b0, transmit_fill_flag);
    repeat (5) partner.window();
    check("fill flag", 1'b1, transmit_fill_flag);
    partner.rx_q.delete();
    partner.window();
    for (int b = 0; b < 8; b++) got[b] = partner.rx_q.pop_front();
    hit = 1'b0;
    for (int r = 0; r < 8; r++)
      if ((({got, got} >> r) & 16'hff) == 16'(dsi_pkg::FLAG_WORD)) hit = 1'b1;
    check("idle flag", 1'b1, hit);
    check("oe seen", 1'b0, partner.oe_bad);
    check("oe_n", 1'b1, sync_serial_oe_n);
    push(8'h00);
    partner.window();
    check("rx status", 1'b0, receive_sync_status);
    push(dsi_pkg::FLAG_WORD);
    partner.window();
    check("rx status", 1'b1, receive_sync_status);
    word = 8'(xs(seed)) & 8'h1f;
    push(word);
    partner.window();
    n = 0;
    while (async_serial_out !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    repeat (96) @(posedge pclk);
    for (int b = 0; b < 8; b++) begin
      got[b] = async_serial_out;
      repeat (64) @(posedge pclk);
    end
    check("async word", word, got);
    check("stop bit", 1'b1, async_serial_out);
    // clock mode high: nine clock pulses per window, only eight may shift
    apb(1'b1, dsi_pkg::CTRL_OFFSET, 32'h1 << dsi_pkg::CTRL_MODE_BIT);
    partner.window(9);
    partner.rx_q.delete();
    partner.window(9);
    for (int b = 0; b < 8; b++) got[b] = partner.rx_q.pop_front();
    check("mode1 flag", dsi_pkg::FLAG_WORD, got);
    check("oe seen", 1'b0, partner.oe_bad);
    // twelve bit times low must read back as a break
    async_serial_in <= 1'b0;
    repeat (768) @(posedge pclk);
    apb(1'b0, dsi_pkg::STATUS_OFFSET, 32'h0);
    check("break", 32'h1, {31'h0, rd[2]});
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

/* inc/dsi_pkg.sv */
package dsi_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  localparam int CTRL_STOP_BIT  = 0;
  localparam int CTRL_WORD_BIT  = 1;
  localparam int CTRL_RATE_LSB  = 2;
  localparam int CTRL_RATE_MSB  = 4;
  localparam int CTRL_MODE_BIT  = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // ------------------------------------------------------------
  // rate generation
  // ------------------------------------------------------------
  // accumulator steps per 4.096 MHz edge, at twice the 16x rate,
  // modulus is the input rate in units of 100 Hz
  localparam logic [16:0] RATE_MODULUS = 17'h0a000;
  localparam logic [7:1][15:0] RATE_STEP = {
    16'h0060, 16'h0180, 16'h0300, 16'h0600, 16'h0c00, 16'h1800, 16'h3000};

  // ------------------------------------------------------------
  // framing and sizes
  // ------------------------------------------------------------
  localparam logic [7:0] FLAG_WORD     = 8'h7e;
  localparam logic [8:0] BREAK_WORD    = 9'h0fe;
  localparam logic [3:0] LAST_BIT_8    = 4'h7;
  localparam logic [3:0] LAST_BIT_9    = 4'h8;
  localparam logic [3:0] WINDOW_BITS   = 4'h8;
  localparam logic [3:0] MID_SAMPLE    = 4'h7;
  localparam logic [3:0] LAST_SAMPLE   = 4'hf;
  localparam logic [7:0] BREAK_TICKS   = 8'hb0;
  localparam logic [2:0] FIFO_DEPTH    = 3'h4;
  localparam logic [2:0] FILL_LIMIT    = 3'h2;
  localparam logic [5:0] SYNC_RESET    = 6'h10;

  // ------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b11,
    SER_STOP  = 2'b10
  } serial_state_type;

endpackage : dsi_pkg
